//--- lsc_regs.vh
// Purpose: constants of the light sensor command and readout block
// Assumes: included by the design files by bare name
// Notes: definitions only
`ifndef LSC_REGS_VH
`define LSC_REGS_VH

// ----------------------------------------
// bus address and data register indices
// ----------------------------------------
`define LSC_DEV_ADDR 7'h44
`define LSC_REG_RES_LO 3'h0
`define LSC_REG_RES_HI 3'h1
`define LSC_REG_CNT_LO 3'h2
`define LSC_REG_CNT_HI 3'h3
`define LSC_NBYTES_INT 3'h2
`define LSC_NBYTES_EXT 3'h4

// ----------------------------------------
// command codes
// ----------------------------------------
`define LSC_CMD_VIS_INT 8'h00
`define LSC_CMD_IR_INT 8'h04
`define LSC_CMD_DIFF_INT 8'h08
`define LSC_CMD_VIS_EXT 8'h30
`define LSC_CMD_IR_EXT 8'h34
`define LSC_CMD_DIFF_EXT 8'h38
`define LSC_CMD_PWRDN 8'h8c
`define LSC_CMD_CONV_RST 8'h0c
`define LSC_CMD_TEST_BIT 7
`define LSC_CMD_RESET_VAL 8'h0c

// ----------------------------------------
// converter source select codes
// ----------------------------------------
`define LSC_SEL_VIS 2'h0
`define LSC_SEL_IR 2'h1
`define LSC_SEL_DIFF 2'h2
`define LSC_SEL_NONE 2'h3

// ----------------------------------------
// timing: oscillator rate in Hz, periods in ms and in oscillator cycles
// ----------------------------------------
`define LSC_OSC_NOM_HZ 327600
`define LSC_T_INT_MS 100
`define LSC_T_DIFF_MS 200
`define LSC_INT_CYCLES 17'h08000
`define LSC_INT_LAST 16'h7fff

`endif

//--- lsc_integ.v
// Purpose: integration counter and period timer
// Assumes: i_tick is a one-cycle pulse per oscillator cycle, same clock
// Notes: internal periods end by count, external ones by i_ext_end
`timescale 1ns/1ns
`include "lsc_regs.vh"
module lsc_integ (
   // clock and control
   input wire i_clk,
   input wire i_rst,
   input wire i_ce,
   // timing controls
   input wire i_tick,
   input wire i_run,
   input wire i_internal,
   input wire i_diff,
   input wire i_restart,
   input wire i_ext_end,
   // results
   output reg o_period_end,
   output reg o_half,
   output reg [15:0] o_count
);

   reg [15:0] cnt_q;
   wire [15:0] cnt_inc = cnt_q + {15'h0000, i_tick};
   wire int_last = i_run && i_internal && i_tick && (cnt_q == `LSC_INT_LAST);

   // ----------------------------------------
   // counter and period end
   // ----------------------------------------
   always @(posedge i_clk) begin
      if (i_rst) begin
         cnt_q <= 16'h0000;
         o_period_end <= 1'b0;
         o_half <= 1'b0;
         o_count <= 16'h0000;
      end else if (i_ce) begin
         o_period_end <= 1'b0;
         if (i_restart || !i_run) begin
            cnt_q <= 16'h0000;
            o_half <= 1'b0;
         end else if (i_ext_end && !i_internal) begin
            o_count <= cnt_inc;
            o_period_end <= 1'b1;
            cnt_q <= 16'h0000;
         end else if (int_last) begin
            // difference mode runs two halves back to back
            cnt_q <= 16'h0000;
            if (i_diff && !o_half) begin
               o_half <= 1'b1;
            end else begin
               o_half <= 1'b0;
               o_count <= cnt_inc;
               o_period_end <= 1'b1;
            end
         end else begin
            cnt_q <= cnt_inc;
         end
      end
   end

endmodule // lsc_integ

//--- lsc_top.v
// Purpose: command decode and result readout of an ambient light sensor
// Assumes: bus pins and oscillator arrive asynchronously; converter data on I_CLK_SYS
// Notes: open-drain data pin as input, output and enable; clock line is input only
`timescale 1ns/1ns
`include "lsc_regs.vh"
// Notes on behaviour
// - 00H visible, 04H infrared: unsigned 16-bit, self-timed nominal 100ms.
// - 08H visible minus infrared, two's complement, self-timed over two periods.
// - 30H and 34H externally timed; each repeat ends one period, starts next.
// - 38H difference externally timed; each repeated 38H closes and reopens integration.
// - other bytes with top bit set, except 8CH power down, are a test; reads return the command value.
// - no register address; reads always stream from the first data register.
// - result low byte first, then high byte.
// - counter low then high byte follow the result.
// - each oscillator cycle during integration with I_CE high increments the 16-bit integration counter.
// - counter copied to its registers at each period end with the result.
// - internally timed modes offer only the two result bytes.
// - internal period is exactly 32768 oscillator cycles.
// - nominal oscillator 327.6kHz gives the 100ms period.
// - only bus address 1000100 is answered.
// - each write replaces the command; operation holds until next write.
// - data registers change only when a conversion completes.
module lsc_top (
   // clock, reset, enable
   input wire I_CLK_SYS,
   input wire I_RST,
   input wire I_CE,
   // serial bus pins
   input wire I_SCL,
   input wire I_SDA,
   output reg O_SDA_OUT,
   output reg O_SDA_OE,
   // oscillator and converter
   input wire I_OSC_CLK,
   input wire [15:0] I_CONV_DATA,
   output reg [1:0] O_CONV_SEL,
   output reg O_CONV_HALF,
   output reg O_CONV_DONE,
   output reg O_PWRDN,
   output reg O_CONV_RST
);

   localparam ST_IDLE = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_AACK = 3'h2;
   localparam ST_WDAT = 3'h3;
   localparam ST_WACK = 3'h4;
   localparam ST_RDAT = 3'h5;
   localparam ST_RACK = 3'h6;

   function is_ext(input [7:0] c);
      is_ext = (c == `LSC_CMD_VIS_EXT) || (c == `LSC_CMD_IR_EXT) || (c == `LSC_CMD_DIFF_EXT);
   endfunction

   function is_int(input [7:0] c);
      is_int = (c == `LSC_CMD_VIS_INT) || (c == `LSC_CMD_IR_INT) || (c == `LSC_CMD_DIFF_INT);
   endfunction

   function [7:0] rd_byte(input [2:0] i, input [31:0] s, input [7:0] c);
      begin
         if (c[`LSC_CMD_TEST_BIT] && c != `LSC_CMD_PWRDN)
            rd_byte = c;
         else begin
            case (i)
               `LSC_REG_RES_LO: rd_byte = s[7:0];
               `LSC_REG_RES_HI: rd_byte = s[15:8];
               `LSC_REG_CNT_LO: rd_byte = s[23:16];
               `LSC_REG_CNT_HI: rd_byte = s[31:24];
               default: rd_byte = 8'hff;
            endcase
         end
      end
   endfunction

   // ----------------------------------------
   // synchronisers and edge detection
   // ----------------------------------------
   reg scl_s1_q, scl_s2_q, scl_s3_q;
   reg sda_s1_q, sda_s2_q, sda_s3_q;
   reg osc_s1_q, osc_s2_q, osc_s3_q;
   always @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
         {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
         {osc_s1_q, osc_s2_q, osc_s3_q} <= 3'h0;
      end else if (I_CE) begin
         {scl_s3_q, scl_s2_q, scl_s1_q} <= {scl_s2_q, scl_s1_q, I_SCL};
         {sda_s3_q, sda_s2_q, sda_s1_q} <= {sda_s2_q, sda_s1_q, I_SDA};
         {osc_s3_q, osc_s2_q, osc_s1_q} <= {osc_s2_q, osc_s1_q, I_OSC_CLK};
      end
   end
   wire scl_rise = scl_s2_q && !scl_s3_q;
   wire scl_fall = !scl_s2_q && scl_s3_q;
   wire bus_start = scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q;
   wire bus_stop = scl_s2_q && scl_s3_q && !sda_s3_q && sda_s2_q;
   wire osc_tick = osc_s2_q && !osc_s3_q;

   // ----------------------------------------
   // command register and data registers
   // ----------------------------------------
   reg [7:0] cmd_q;
   reg [15:0] res_q, cnt_reg_q;
   reg cmd_wr_q;
   reg [7:0] wr_val_q;
   wire [15:0] integ_count;
   wire period_end, integ_half;
   wire cmd_run = is_int(cmd_q) || is_ext(cmd_q);
   wire same_ext = cmd_wr_q && is_ext(wr_val_q) && (wr_val_q == cmd_q);
   wire restart = cmd_wr_q && !same_ext;

   always @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         cmd_q <= `LSC_CMD_RESET_VAL;
         res_q <= 16'h0000;
         cnt_reg_q <= 16'h0000;
         O_CONV_SEL <= `LSC_SEL_NONE;
         O_CONV_HALF <= 1'b0;
         O_CONV_DONE <= 1'b0;
         O_PWRDN <= 1'b0;
         O_CONV_RST <= 1'b1;
      end else if (I_CE) begin
         if (cmd_wr_q)
            cmd_q <= wr_val_q;
         // capture only after the period closed, so result and count pair
         if (period_end) begin
            res_q <= I_CONV_DATA;
            cnt_reg_q <= integ_count;
         end
         O_CONV_DONE <= period_end;
         O_CONV_HALF <= integ_half;
         O_PWRDN <= (cmd_q == `LSC_CMD_PWRDN);
         O_CONV_RST <= (cmd_q == `LSC_CMD_CONV_RST) || restart;
         if (cmd_q == `LSC_CMD_VIS_INT || cmd_q == `LSC_CMD_VIS_EXT)
            O_CONV_SEL <= `LSC_SEL_VIS;
         else if (cmd_q == `LSC_CMD_IR_INT || cmd_q == `LSC_CMD_IR_EXT)
            O_CONV_SEL <= `LSC_SEL_IR;
         else if (cmd_q == `LSC_CMD_DIFF_INT || cmd_q == `LSC_CMD_DIFF_EXT)
            O_CONV_SEL <= `LSC_SEL_DIFF;
         else
            O_CONV_SEL <= `LSC_SEL_NONE;
      end
   end

   // ----------------------------------------
   // integration timing
   // ----------------------------------------
   lsc_integ u_integ (
      .i_clk(I_CLK_SYS),
      .i_rst(I_RST),
      .i_ce(I_CE),
      .i_tick(osc_tick),
      .i_run(cmd_run),
      .i_internal(is_int(cmd_q)),
      .i_diff(cmd_q == `LSC_CMD_DIFF_INT),
      .i_restart(restart),
      .i_ext_end(same_ext),
      .o_period_end(period_end),
      .o_half(integ_half),
      .o_count(integ_count)
   );

   // ----------------------------------------
   // serial bus slave
   // ----------------------------------------
   reg [2:0] st_q;
   reg [3:0] bit_q;
   reg [7:0] shift_q, tx_q;
   reg rw_q, avail_q;
   reg [2:0] idx_q;
   reg [31:0] snap_q;
   // internal modes stop after the result; external and test give all four
   wire [2:0] nbytes = is_int(cmd_q) ? `LSC_NBYTES_INT : `LSC_NBYTES_EXT;
   wire [7:0] next_byte = rd_byte(idx_q, snap_q, cmd_q);

   always @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         st_q <= ST_IDLE;
         bit_q <= 4'h0;
         shift_q <= 8'h00;
         tx_q <= 8'h00;
         rw_q <= 1'b0;
         avail_q <= 1'b0;
         idx_q <= 3'h0;
         snap_q <= 32'h00000000;
         cmd_wr_q <= 1'b0;
         wr_val_q <= 8'h00;
         O_SDA_OUT <= 1'b0;
         O_SDA_OE <= 1'b0;
      end else if (I_CE) begin
         cmd_wr_q <= 1'b0;
         if (bus_start) begin
            st_q <= ST_ADDR;
            bit_q <= 4'h0;
            O_SDA_OE <= 1'b0;
         end else if (bus_stop) begin
            st_q <= ST_IDLE;
            O_SDA_OE <= 1'b0;
         end else begin
            case (st_q)
               ST_ADDR, ST_WDAT: begin
                  if (scl_rise && bit_q != 4'h8) begin
                     shift_q <= {shift_q[6:0], sda_s2_q};
                     bit_q <= bit_q + 4'h1;
                  end else if (scl_fall && bit_q == 4'h8) begin
                     if (st_q == ST_WDAT) begin
                        O_SDA_OE <= 1'b1;
                        wr_val_q <= shift_q;
                        cmd_wr_q <= 1'b1;
                        st_q <= ST_WACK;
                     end else if (shift_q[7:1] == `LSC_DEV_ADDR) begin
                        O_SDA_OE <= 1'b1;
                        rw_q <= shift_q[0];
                        idx_q <= `LSC_REG_RES_LO;
                        snap_q <= {cnt_reg_q, res_q};
                        st_q <= ST_AACK;
                     end else
                        st_q <= ST_IDLE;
                  end
               end
               ST_WACK: begin
                  if (scl_fall) begin
                     O_SDA_OE <= 1'b0;
                     bit_q <= 4'h0;
                     st_q <= ST_WDAT;
                  end
               end
               ST_AACK, ST_RACK: begin
                  if (st_q == ST_RACK && scl_rise && sda_s2_q)
                     st_q <= ST_IDLE;
                  else if (scl_fall && st_q == ST_AACK && !rw_q) begin
                     O_SDA_OE <= 1'b0;
                     bit_q <= 4'h0;
                     st_q <= ST_WDAT;
                  end else if (scl_fall) begin
                     avail_q <= (idx_q < nbytes);
                     tx_q <= next_byte;
                     O_SDA_OE <= (idx_q < nbytes) && !next_byte[7];
                     idx_q <= idx_q + 3'h1;
                     bit_q <= 4'h0;
                     st_q <= ST_RDAT;
                  end
               end
               ST_RDAT: begin
                  if (scl_fall) begin
                     if (bit_q == 4'h7) begin
                        O_SDA_OE <= 1'b0;
                        st_q <= ST_RACK;
                     end else begin
                        tx_q <= {tx_q[6:0], 1'b0};
                        O_SDA_OE <= avail_q && !tx_q[6];
                        bit_q <= bit_q + 4'h1;
                     end
                  end
               end
               default: st_q <= ST_IDLE;
            endcase
         end
      end
   end

endmodule // lsc_top

//--- lsc_top_assertions.sv
// Purpose: port-level checks of the light sensor readout block
// Assumes: bus low phases last well beyond the pin synchroniser delay
// Notes: bound to every lsc_top instance
`timescale 1ns/1ns
module lsc_top_assertions (
   // clock and reset
   input wire I_CLK_SYS,
   input wire I_RST,
   // watched pins
   input wire I_SCL,
   input wire O_SDA_OUT,
   input wire O_SDA_OE,
   input wire [1:0] O_CONV_SEL,
   input wire O_CONV_HALF,
   input wire O_CONV_DONE,
   input wire O_PWRDN
);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (I_RST);
   sda_open_drain_a: assert property (O_SDA_OUT == 1'b0)
      else $error("data pin driven high");
   sda_scl_low_a: assert property ($changed(O_SDA_OE) |-> !I_SCL)
      else $error("data pin moved while clock high");
   cmd_scl_low_a: assert property ($changed(O_CONV_SEL) |-> !I_SCL)
      else $error("mode changed outside a bus low phase");
   pwrdn_no_sel_a: assert property (O_PWRDN [*2] |-> O_CONV_SEL == 2'h3 && !O_CONV_HALF)
      else $error("converter active while powered down");
   half_diff_only_a: assert property (O_CONV_HALF |-> O_CONV_SEL == 2'h2)
      else $error("half period outside difference mode");
   done_pulse_a: assert property (O_CONV_DONE |=> !O_CONV_DONE)
      else $error("done longer than one cycle");
   done_active_a: assert property (O_CONV_DONE |-> O_CONV_SEL != 2'h3 && !O_PWRDN)
      else $error("capture without an active mode");
   done_same_mode_a: assert property (O_CONV_DONE |-> $past(O_CONV_SEL, 2) == O_CONV_SEL)
      else $error("capture right after a mode switch");
endmodule // lsc_top_assertions

bind lsc_top lsc_top_assertions u_lsc_top_assertions (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_SCL(I_SCL),
   .O_SDA_OUT(O_SDA_OUT), .O_SDA_OE(O_SDA_OE), .O_CONV_SEL(O_CONV_SEL), .O_CONV_HALF(O_CONV_HALF),
   .O_CONV_DONE(O_CONV_DONE), .O_PWRDN(O_PWRDN));

//--- lsc_host.sv
// Purpose: serial bus master model facing the sensor block
// Assumes: data wire is pulled high when nobody pulls it low
// Notes: quarter bit of 10 system cycles keeps clock high far above 4 cycles
`timescale 1ns/1ns
module lsc_host (
   // timing reference
   input wire i_clk,
   // bus pins
   input wire i_sda,
   output reg o_scl,
   output reg o_sda_oe
);
   // ----------------------------------------
   // bit and byte tasks
   // ----------------------------------------
   initial begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
   end
   task qtr;
      repeat (10) @(negedge i_clk);
   endtask
   task start_bit;
      begin
         qtr;
         o_sda_oe = 1'b1;
         qtr;
         o_scl = 1'b0;
         qtr;
      end
   endtask
   task stop_bit;
      begin
         o_sda_oe = 1'b1;
         qtr;
         o_scl = 1'b1;
         qtr;
         o_sda_oe = 1'b0;
         qtr;
      end
   endtask
   // data set while clock low, sampled in the middle of the high phase
   task xbit(input b, output r);
      begin
         o_sda_oe = !b;
         qtr;
         o_scl = 1'b1;
         qtr;
         r = i_sda;
         qtr;
         o_scl = 1'b0;
         qtr;
      end
   endtask
   task xbyte(input [7:0] d, input a, output [7:0] r, output k);
      integer n;
      begin
         for (n = 7; n >= 0; n = n - 1) begin
            xbit(d[n], r[n]);
         end
         xbit(a, k);
      end
   endtask
endmodule // lsc_host

//--- lsc_top_tb.sv
// Purpose: self-checking bench of the light sensor readout block
// Assumes: oscillator runs free at 32 ns, out of phase with the clock
// Notes: internal periods exceed the run length; captures use external timing
`timescale 1ns/1ns
module lsc_top_tb;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg ce = 1'b1;
   reg osc = 1'b0;
   reg [15:0] conv = 16'h0000;
   wire scl, h_oe, sda_oe, half, done, pwrdn, crst;
   wire [1:0] sel;
   wire sda = ~(h_oe | sda_oe);
   integer num_errors = 0;
   integer total_checks = 0;
   integer nt = 0;
   integer nd = 0;
   integer i, j, e;
   reg [31:0] v;
   reg [7:0] r;
   reg k;
   initial forever #2 clk = ~clk;
   initial begin
      #5;
      forever #16 osc = ~osc;
   end
   always @(posedge osc) nt = nt + 1;
   always @(negedge clk) if (done === 1'b1) nd = nd + 1;
   lsc_top u_lsc_top (.I_CLK_SYS(clk), .I_RST(rst), .I_CE(ce), .I_SCL(scl), .I_SDA(sda), .O_SDA_OUT(),
      .O_SDA_OE(sda_oe), .I_OSC_CLK(osc), .I_CONV_DATA(conv), .O_CONV_SEL(sel), .O_CONV_HALF(half),
      .O_CONV_DONE(done), .O_PWRDN(pwrdn), .O_CONV_RST(crst));
   lsc_host u_lsc_host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(h_oe));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task complete_run;
      begin
         if (num_errors == 0 && total_checks > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   task chk(input [31:0] g, input [31:0] x);
      begin
         total_checks = total_checks + 1;
         if (g !== x) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, x);
         end
      end
   endtask
   task wr(input [6:0] a, input [7:0] d);
      begin
         u_lsc_host.start_bit;
         u_lsc_host.xbyte({a, 1'b0}, 1'b1, r, k);
         chk(k, a != 7'h44);
         if (k === 1'b0) begin
            u_lsc_host.xbyte(d, 1'b1, r, k);
            chk(k, 0);
         end
         u_lsc_host.stop_bit;
         repeat (3) @(negedge clk);
      end
   endtask
   // master acknowledges all bytes but the last one
   task rd(input integer n);
      begin
         v = 32'h0;
         u_lsc_host.start_bit;
         u_lsc_host.xbyte({7'h44, 1'b1}, 1'b1, r, k);
         chk(k, 0);
         for (i = 0; i < n; i = i + 1) begin
            u_lsc_host.xbyte(8'hff, i == n - 1, r, k);
            v[8 * i +: 8] = r;
         end
         u_lsc_host.stop_bit;
      end
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (100000) @(posedge clk);
      num_errors = num_errors + 1;
      complete_run;
   end
   initial begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      chk({sel, pwrdn, crst, sda_oe}, {2'h3, 3'b010});
      wr(7'h44, 8'h8c);
      chk({sel, pwrdn}, {2'h3, 1'b1});
      wr(7'h45, 8'h0c);
      chk(pwrdn, 1);
      wr(7'h44, 8'h0c);
      chk({pwrdn, crst}, 2'b01);
      wr(7'h44, 8'ha5);
      rd(4);
      chk(v, 32'ha5a5a5a5);
      for (j = 0; j < 6; j = j + 1) begin
         wr(7'h44, 8'((j / 3) * 8'h30 + (j % 3) * 4));
         chk(sel, j % 3);
      end
      wr(7'h44, 8'h00);
      rd(3);
      chk({nd[7:0], v[23:0]}, 32'h00ff0000);
      conv = 16'h8123;
      wr(7'h44, 8'h30);
      nt = 0;
      // spacing stays far below the counter overflow
      repeat (250) @(posedge osc);
      // about 100 ticks with the enable low must not be counted
      @(negedge clk);
      ce = 1'b0;
      repeat (100) @(posedge osc);
      @(negedge clk);
      ce = 1'b1;
      repeat (250) @(posedge osc);
      @(negedge clk);
      wr(7'h44, 8'h30);
      e = nt;
      conv = 16'h4567;
      chk(nd, 1);
      rd(4);
      chk(v[15:0], 16'h8123);
      e = v[31:16] - e;
      chk(e >= -105 && e <= -97, 1);
      wr(7'h44, 8'h38);
      chk(nd, 1);
      wr(7'h44, 8'h38);
      rd(2);
      chk({nd[15:0], v[15:0]}, {16'h0002, 16'h4567});
      complete_run;
   end
endmodule // lsc_top_tb
